// File: hdl/arlc_pkg.sv
// arlc_pkg: constants, register map and carrier types for the record level control block
// assumes an apb master on clk, byte-wide registers in the low bits of each word
// ==========================================================================
// How it works
// - bit4 set skips high-pass filter
// - low nibble tunes high-pass output
// - bit5 set bypasses level control
// - bit6 set bypasses low-pass filter
// - bit7 enables extra halving down-sample
// - channel bit7 picks auto or manual
// - manual mode gain is bits 5:0
// - auto gain never below channel minimum
// - auto gain above upper limit only when channel minimum is higher
// - thresholds: bit0 half dB, 6:1 dB
// - readback shows current gain or volume
// - sixteen-bit tick period, resets 0x0200
// - config holds five level-control enables
// - mask samples after each auto gain change
// - gain rises at programmed speed
// - fifo pointers and count readable bytewise
// - manual fifo mode takes software words
// - per-tick gain rise limited, resets 3
package arlc_pkg;

  // ==========================================================================
  // register indices (printed offsets are not all word aligned)
  localparam logic [11:0] ARLC_IDX_LEFT = 12'hb41;
  localparam logic [11:0] ARLC_IDX_RIGHT = 12'hb42;
  localparam logic [11:0] ARLC_IDX_MAXG = 12'hb43;
  localparam logic [11:0] ARLC_IDX_THH = 12'hb44;
  localparam logic [11:0] ARLC_IDX_THL = 12'hb46;
  localparam logic [11:0] ARLC_IDX_THN = 12'hb48;
  localparam logic [11:0] ARLC_IDX_CURL = 12'hb4d;
  localparam logic [11:0] ARLC_IDX_CURR = 12'hb4e;
  localparam logic [11:0] ARLC_IDX_TICKL = 12'hb50;
  localparam logic [11:0] ARLC_IDX_TICKH = 12'hb51;
  localparam logic [11:0] ARLC_IDX_CFG = 12'hb54;
  localparam logic [11:0] ARLC_IDX_COEF = 12'hb55;
  localparam logic [11:0] ARLC_IDX_MASK = 12'hb56;
  localparam logic [11:0] ARLC_IDX_RISE = 12'hb57;
  localparam logic [11:0] ARLC_IDX_RMAX = 12'hb58;
  localparam logic [11:0] ARLC_IDX_FILT = 12'hb30;
  localparam logic [11:0] ARLC_IDX_RPL = 12'hb31;
  localparam logic [11:0] ARLC_IDX_RPH = 12'hb32;
  localparam logic [11:0] ARLC_IDX_WPL = 12'hb33;
  localparam logic [11:0] ARLC_IDX_WPH = 12'hb34;
  localparam logic [11:0] ARLC_IDX_CNTL = 12'hb35;
  localparam logic [11:0] ARLC_IDX_CNTH = 12'hb36;
  localparam logic [11:0] ARLC_IDX_FMODE = 12'hb37;
  localparam logic [11:0] ARLC_IDX_FDAT0 = 12'hb38;
  localparam logic [11:0] ARLC_IDX_FDAT1 = 12'hb39;

  // ==========================================================================
  // reset values
  localparam logic [7:0] ARLC_RST_LEVEL = 8'h20;
  localparam logic [7:0] ARLC_RST_MAXG = 8'h33;
  localparam logic [7:0] ARLC_RST_THH = 8'h60;
  localparam logic [7:0] ARLC_RST_THL = 8'h40;
  localparam logic [7:0] ARLC_RST_THN = 8'h02;
  localparam logic [7:0] ARLC_RST_TICKL = 8'h00;
  localparam logic [7:0] ARLC_RST_TICKH = 8'h02;
  localparam logic [7:0] ARLC_RST_CFG = 8'h0a;
  localparam logic [7:0] ARLC_RST_COEF = 8'hfa;
  localparam logic [7:0] ARLC_RST_MASK = 8'h00;
  localparam logic [7:0] ARLC_RST_RISE = 8'h0a;
  localparam logic [7:0] ARLC_RST_RMAX = 8'h03;
  localparam logic [7:0] ARLC_RST_FILT = 8'hfb;

  // ==========================================================================
  // field positions
  localparam int ARLC_B_HPF_BYP = 4;
  localparam int ARLC_B_LVL_BYP = 5;
  localparam int ARLC_B_LPF_BYP = 6;
  localparam int ARLC_B_DOWN2 = 7;
  localparam int ARLC_B_AUTO = 7;
  localparam logic [9:0] ARLC_FIFO_DEPTH_M1 = 10'h3ff;

  typedef struct packed {
    logic hpf_bypass;
    logic [3:0] hpf_adjust;
    logic level_bypass;
    logic lpf_bypass;
    logic down2_en;
    logic [4:0] cfg_enables;
    logic [7:0] coef;
  } arlc_path_type;

  typedef struct packed {
    logic [7:0] left;
    logic [7:0] right;
    logic [7:0] maxg;
    logic [7:0] thh;
    logic [7:0] thl;
    logic [7:0] thn;
    logic [7:0] tickl;
    logic [7:0] tickh;
    logic [7:0] cfg;
    logic [7:0] coef;
    logic [7:0] mask;
    logic [7:0] rise;
    logic [7:0] rmax;
    logic [7:0] filt;
    logic fmode;
    logic [7:0] fdat_lo;
  } arlc_regs_type;

  typedef struct packed {
    logic [6:0] gain;
    logic [6:0] stepped;
    logic [7:0] speed_cnt;
    logic [15:0] peak;
    logic [3:0] mask_cnt;
  } arlc_chan_type;

  typedef enum logic [1:0] {
    ARLC_HOLD,
    ARLC_RISE,
    ARLC_FALL
  } arlc_dir_type;

endpackage

// File: hdl/arlc_top.sv
// arlc_top: apb register bank and level-control engine for the audio record path
// assumes samples arrive as a valid-qualified stream on clk, one channel select per sample
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
module arlc_top
  import arlc_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic smp_valid,
  input wire logic smp_right,
  input wire logic [15:0] smp_data,
  input wire logic fifo_pop,
  output logic [15:0] out_data,
  output logic out_valid,
  output logic out_right,
  output logic out_masked,
  output arlc_path_type path_cfg,
  output logic [6:0] left_gain,
  output logic [6:0] right_gain
);

  // ==========================================================================
  // state
  typedef struct packed {
    arlc_regs_type regs;
    arlc_chan_type [1:0] ch;
    logic [15:0] tick_cnt;
    logic [9:0] rptr;
    logic [9:0] wptr;
    logic [10:0] count;
    logic down2_phase;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] out_data;
    logic out_valid;
    logic out_right;
    logic out_masked;
    arlc_path_type path;
  } arlc_state_type;

  arlc_state_type st_r, st_nxt;

  // word count only; fifo storage is the shared record buffer outside this block
  localparam logic [10:0] FULL_COUNT = 11'h400;

  function automatic logic [6:0] clamp7(input logic [7:0] v, input logic [6:0] lo, input logic [6:0] hi);
    logic [6:0] r;
    r = (v > {1'b0, hi}) ? hi : v[6:0];
    if (r < lo) begin
      r = lo;
    end
    return r;
  endfunction

  // threshold as half-dB units: integer dB in 6:1, half dB in bit 0
  function automatic logic [15:0] thr_level(input logic [7:0] t);
    return {2'h0, t[6:1], t[0], 7'h00};
  endfunction

  function automatic logic [15:0] absv(input logic [15:0] s);
    return s[15] ? 16'(~s + 16'h0001) : s;
  endfunction

  logic [11:0] idx;
  logic acc;
  logic wr;
  assign idx = paddr[13:2];
  assign acc = psel && penable && !st_r.pready;
  assign wr = acc && pwrite;

  // ==========================================================================
  // next state
  always_comb begin
    logic [15:0] mag;
    logic [7:0] lvl;
    logic auto_m;
    logic [6:0] g;
    logic [6:0] up;
    logic [15:0] period;
    logic tick;
    logic push;
    logic pop;
    logic [7:0] rd;
    st_nxt = st_r;
    mag = 16'h0000;
    lvl = 8'h00;
    auto_m = 1'b0;
    g = 7'h00;
    up = 7'h00;
    rd = 8'h00;
    period = {st_r.regs.tickh, st_r.regs.tickl};
    tick = (st_r.tick_cnt >= period);
    push = 1'b0;
    pop = fifo_pop && (st_r.count != 11'h000);

    // apb slave: one wait state, answer on the second access cycle
    st_nxt.pready = acc;
    st_nxt.pslverr = 1'b0;
    if (wr) begin
      case (idx)
        ARLC_IDX_LEFT: st_nxt.regs.left = pwdata[7:0];
        ARLC_IDX_RIGHT: st_nxt.regs.right = pwdata[7:0];
        ARLC_IDX_MAXG: st_nxt.regs.maxg = pwdata[7:0];
        ARLC_IDX_THH: st_nxt.regs.thh = pwdata[7:0];
        ARLC_IDX_THL: st_nxt.regs.thl = pwdata[7:0];
        ARLC_IDX_THN: st_nxt.regs.thn = pwdata[7:0];
        ARLC_IDX_TICKL: st_nxt.regs.tickl = pwdata[7:0];
        ARLC_IDX_TICKH: st_nxt.regs.tickh = pwdata[7:0];
        ARLC_IDX_CFG: st_nxt.regs.cfg = pwdata[7:0];
        ARLC_IDX_COEF: st_nxt.regs.coef = pwdata[7:0];
        ARLC_IDX_MASK: st_nxt.regs.mask = pwdata[7:0];
        ARLC_IDX_RISE: st_nxt.regs.rise = pwdata[7:0];
        ARLC_IDX_RMAX: st_nxt.regs.rmax = pwdata[7:0];
        ARLC_IDX_FILT: st_nxt.regs.filt = pwdata[7:0];
        ARLC_IDX_FMODE: st_nxt.regs.fmode = pwdata[0];
        ARLC_IDX_FDAT0: st_nxt.regs.fdat_lo = pwdata[7:0];
        // high byte completes the word; only taken in software fill mode
        ARLC_IDX_FDAT1: push = st_r.regs.fmode;
        default: ;
      endcase
    end
    case (idx)
      ARLC_IDX_LEFT: rd = st_r.regs.left;
      ARLC_IDX_RIGHT: rd = st_r.regs.right;
      ARLC_IDX_MAXG: rd = st_r.regs.maxg;
      ARLC_IDX_THH: rd = st_r.regs.thh;
      ARLC_IDX_THL: rd = st_r.regs.thl;
      ARLC_IDX_THN: rd = st_r.regs.thn;
      ARLC_IDX_CURL: rd = {1'b0, st_r.ch[0].gain};
      ARLC_IDX_CURR: rd = {1'b0, st_r.ch[1].gain};
      ARLC_IDX_TICKL: rd = st_r.regs.tickl;
      ARLC_IDX_TICKH: rd = st_r.regs.tickh;
      ARLC_IDX_CFG: rd = st_r.regs.cfg;
      ARLC_IDX_COEF: rd = st_r.regs.coef;
      ARLC_IDX_MASK: rd = st_r.regs.mask;
      ARLC_IDX_RISE: rd = st_r.regs.rise;
      ARLC_IDX_RMAX: rd = st_r.regs.rmax;
      ARLC_IDX_FILT: rd = st_r.regs.filt;
      ARLC_IDX_RPL: rd = st_r.rptr[7:0];
      ARLC_IDX_RPH: rd = {6'h00, st_r.rptr[9:8]};
      ARLC_IDX_WPL: rd = st_r.wptr[7:0];
      ARLC_IDX_WPH: rd = {6'h00, st_r.wptr[9:8]};
      ARLC_IDX_CNTL: rd = st_r.count[7:0];
      ARLC_IDX_CNTH: rd = {5'h00, st_r.count[10:8]};
      ARLC_IDX_FMODE: rd = {7'h00, st_r.regs.fmode};
      default: rd = 8'h00;
    endcase
    st_nxt.prdata = (acc && !pwrite) ? {24'h000000, rd} : 32'h00000000;

    // filter path controls for the downstream datapath
    st_nxt.path.hpf_adjust = st_r.regs.filt[3:0];
    st_nxt.path.hpf_bypass = st_r.regs.filt[ARLC_B_HPF_BYP];
    st_nxt.path.level_bypass = st_r.regs.filt[ARLC_B_LVL_BYP];
    st_nxt.path.lpf_bypass = st_r.regs.filt[ARLC_B_LPF_BYP];
    st_nxt.path.down2_en = st_r.regs.filt[ARLC_B_DOWN2];
    st_nxt.path.cfg_enables = st_r.regs.cfg[4:0];
    st_nxt.path.coef = st_r.regs.coef;

    // tick counter for peak evaluation
    st_nxt.tick_cnt = tick ? 16'h0000 : 16'(st_r.tick_cnt + 16'h0001);

    // sample processing per channel
    st_nxt.out_valid = 1'b0;
    for (int c = 0; c < 2; c++) begin
      lvl = (c == 0) ? st_r.regs.left : st_r.regs.right;
      auto_m = lvl[ARLC_B_AUTO];
      if (!auto_m) begin
        st_nxt.ch[c].gain = {1'b0, lvl[5:0]};
        st_nxt.ch[c].mask_cnt = 4'h0;
      end else if (tick) begin
        // peak compared with thresholds once per tick period
        g = st_r.ch[c].gain;
        if (st_r.ch[c].peak > thr_level(st_r.regs.thh)) begin
          g = (g != 7'h00) ? 7'(g - 7'h01) : g;
        end else if (st_r.ch[c].peak < thr_level(st_r.regs.thl) &&
                     st_r.ch[c].peak >= thr_level(st_r.regs.thn)) begin
          // rise only after the programmed speed count, capped per tick
          if (st_r.ch[c].speed_cnt >= st_r.regs.rise) begin
            if (st_r.ch[c].stepped < st_r.regs.rmax[6:0]) begin
              g = 7'(g + 7'h01);
              st_nxt.ch[c].stepped = 7'(st_r.ch[c].stepped + 7'h01);
            end
            st_nxt.ch[c].speed_cnt = 8'h00;
          end else begin
            st_nxt.ch[c].speed_cnt = 8'(st_r.ch[c].speed_cnt + 8'h01);
          end
        end
        up = clamp7({1'b0, g}, lvl[6:0], st_r.regs.maxg[6:0]);
        st_nxt.ch[c].gain = up;
        if (up != st_r.ch[c].gain) begin
          st_nxt.ch[c].mask_cnt = st_r.regs.mask[3:0];
        end
        st_nxt.ch[c].peak = 16'h0000;
      end
      if (tick && st_r.ch[c].speed_cnt == 8'h00) begin
        st_nxt.ch[c].stepped = 7'h00;
      end
    end

    if (smp_valid && !st_r.regs.fmode) begin
      mag = absv(smp_data);
      st_nxt.down2_phase = st_r.regs.filt[ARLC_B_DOWN2] ? !st_r.down2_phase : 1'b0;
      // a sample on the tick edge opens the next window instead of being lost
      if (tick || mag > st_r.ch[smp_right].peak) begin
        st_nxt.ch[smp_right].peak = mag;
      end
      if (!st_r.down2_phase) begin
        st_nxt.out_valid = 1'b1;
        st_nxt.out_right = smp_right;
        st_nxt.out_data = smp_data;
        st_nxt.out_masked = st_r.ch[smp_right].mask_cnt != 4'h0;
        push = 1'b1;
        // only a reload on this tick wins over the countdown
        if (st_r.ch[smp_right].mask_cnt != 4'h0 &&
            !(tick && st_nxt.ch[smp_right].gain != st_r.ch[smp_right].gain)) begin
          st_nxt.ch[smp_right].mask_cnt = 4'(st_r.ch[smp_right].mask_cnt - 4'h1);
        end
      end
    end
    if (wr && idx == ARLC_IDX_FDAT1 && st_r.regs.fmode) begin
      st_nxt.out_valid = 1'b1;
      st_nxt.out_data = {pwdata[7:0], st_r.regs.fdat_lo};
      st_nxt.out_masked = 1'b0;
    end

    // fifo bookkeeping; pushes beyond full are dropped
    if (push && st_r.count == FULL_COUNT) begin
      push = 1'b0;
    end
    if (push) begin
      st_nxt.wptr = 10'(st_r.wptr + 10'h001);
    end
    if (pop) begin
      st_nxt.rptr = 10'(st_r.rptr + 10'h001);
    end
    st_nxt.count = 11'(st_r.count + {10'h000, push} - {10'h000, pop});
  end

  // ==========================================================================
  // registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '0;
      st_r.regs.left <= ARLC_RST_LEVEL;
      st_r.regs.right <= ARLC_RST_LEVEL;
      st_r.regs.maxg <= ARLC_RST_MAXG;
      st_r.regs.thh <= ARLC_RST_THH;
      st_r.regs.thl <= ARLC_RST_THL;
      st_r.regs.thn <= ARLC_RST_THN;
      st_r.regs.tickl <= ARLC_RST_TICKL;
      st_r.regs.tickh <= ARLC_RST_TICKH;
      st_r.regs.cfg <= ARLC_RST_CFG;
      st_r.regs.coef <= ARLC_RST_COEF;
      st_r.regs.mask <= ARLC_RST_MASK;
      st_r.regs.rise <= ARLC_RST_RISE;
      st_r.regs.rmax <= ARLC_RST_RMAX;
      st_r.regs.filt <= ARLC_RST_FILT;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign out_data = st_r.out_data;
  assign out_valid = st_r.out_valid;
  assign out_right = st_r.out_right;
  assign out_masked = st_r.out_masked;
  assign path_cfg = st_r.path;
  assign left_gain = st_r.ch[0].gain;
  assign right_gain = st_r.ch[1].gain;

endmodule // arlc_top

// File: bench/arlc_top_props.sv
// arlc_top_props: concurrent checks on the record level control ports
// assumes an apb master that holds each request until pready; bound onto arlc_top
`timescale 1ns/1ps
module arlc_top_props
  import arlc_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic smp_valid,
  input wire logic smp_right,
  input wire logic out_valid,
  input wire logic out_right,
  input wire arlc_path_type path_cfg,
  input wire logic [6:0] left_gain
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  // ==========================================================================
  // helpers
  logic [5:0] lg_r;

  sequence wr_done(logic [11:0] idx);
    psel && penable && pready && pwrite && paddr[13:2] == idx;
  endsequence

  // last manual gain written, so a late gain update is still judged
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lg_r <= '0;
    end else if (psel && penable && pready && pwrite && paddr[13:2] == ARLC_IDX_LEFT) begin
      lg_r <= pwdata[5:0];
    end
  end

  // ==========================================================================
  // properties
  access_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("no answer one cycle after access");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  ready_qual_a: assert property (pready |-> psel && penable)
    else $error("pready outside an access");
  no_error_a: assert property (!pslverr)
    else $error("error response given");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer cycle");
  hpf_fields_a: assert property (wr_done(ARLC_IDX_FILT) |=> ##1
    {path_cfg.hpf_bypass, path_cfg.hpf_adjust} == $past(pwdata[4:0], 2)) else $error("hpf fields wrong");
  bypass_fields_a: assert property (wr_done(ARLC_IDX_FILT) |=> ##1
    {path_cfg.down2_en, path_cfg.lpf_bypass, path_cfg.level_bypass} == $past(pwdata[7:5], 2))
    else $error("bypass fields wrong");
  cfg_enables_a: assert property (wr_done(ARLC_IDX_CFG) |=> ##1
    path_cfg.cfg_enables == $past(pwdata[4:0], 2)) else $error("config enables wrong");
  manual_gain_a: assert property (wr_done(ARLC_IDX_LEFT) ##0 !pwdata[7] |=> ##[0:3]
    left_gain == {1'b0, lg_r}) else $error("manual gain not applied");
  sample_fwd_a: assert property (smp_valid && !path_cfg.down2_en |=>
    out_valid && out_right == $past(smp_right)) else $error("sample not forwarded");
  out_pulse_a: assert property (!smp_valid &&
    !(psel && penable && !pready && pwrite && paddr[13:2] == ARLC_IDX_FDAT1) |=> !out_valid)
    else $error("output without sample");
endmodule // arlc_top_props

bind arlc_top arlc_top_props arlc_top_props_inst (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .smp_valid(smp_valid), .smp_right(smp_right), .out_valid(out_valid), .out_right(out_right),
  .path_cfg(path_cfg), .left_gain(left_gain));

// File: bench/arlc_sample_src.sv
// arlc_sample_src: behavioural audio adc sample source for the record path
// assumes send() is called from one process only, channels alternate
`timescale 1ns/1ps
module arlc_sample_src (
  input wire logic clk,
  output logic smp_valid,
  output logic smp_right,
  output logic [15:0] smp_data
);
  initial begin
    smp_valid = 1'b0;
    smp_right = 1'b0;
    smp_data = 16'h0;
  end

  // ==========================================================================
  // sample stream, gap gives prompt or slow pacing
  task automatic send(input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      smp_valid <= 1'b1;
      smp_right <= i[0];
      smp_data <= 16'h1200 + 16'(i);
      @(posedge clk);
      smp_valid <= 1'b0;
      smp_data <= ~smp_data; // stale data never repeats the last sample
      repeat (gap) @(posedge clk);
    end
  endtask
endmodule // arlc_sample_src

// File: bench/arlc_top_bench.sv
// arlc_top_bench: self-checking bench for the record level control register bank
// assumes arlc_top with its bound checker and the sample source model
`timescale 1ns/1ps
module arlc_top_bench
  import arlc_pkg::*;
;
  logic clk, resetn, psel, penable, pwrite, fifo_pop;
  logic [31:0] paddr, pwdata, prdata;
  logic pready, pslverr, smp_valid, smp_right, out_valid, out_right, out_masked;
  logic [15:0] smp_data, out_data;
  arlc_path_type path_cfg;
  logic [6:0] left_gain, right_gain;
  logic [7:0] rdv;
  int failures, checks_done, cycles, outs, masks;
  localparam logic [11:0] rw_idx [14] = '{ARLC_IDX_LEFT, ARLC_IDX_RIGHT, ARLC_IDX_MAXG, ARLC_IDX_THH,
    ARLC_IDX_THL, ARLC_IDX_THN, ARLC_IDX_TICKL, ARLC_IDX_TICKH, ARLC_IDX_CFG, ARLC_IDX_COEF,
    ARLC_IDX_MASK, ARLC_IDX_RISE, ARLC_IDX_RMAX, ARLC_IDX_FILT};
  localparam logic [7:0] rw_rst [14] = '{8'h20, 8'h20, 8'h33, 8'h60, 8'h40, 8'h02, 8'h00, 8'h02,
    8'h0a, 8'hfa, 8'h00, 8'h0a, 8'h03, 8'hfb};
  localparam logic [11:0] rsv_idx [4] = '{12'hb45, 12'hb47, 12'hb4f, 12'hb52};

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  arlc_top arlc_top_inst (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .smp_valid(smp_valid), .smp_right(smp_right), .smp_data(smp_data), .fifo_pop(fifo_pop),
    .out_data(out_data), .out_valid(out_valid), .out_right(out_right), .out_masked(out_masked),
    .path_cfg(path_cfg), .left_gain(left_gain), .right_gain(right_gain));

  arlc_sample_src arlc_sample_src_inst (.clk(clk), .smp_valid(smp_valid), .smp_right(smp_right),
    .smp_data(smp_data));

  // ==========================================================================
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] idx, input logic [7:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {18'h0, idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdv = prdata[7:0];
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [11:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk({24'h0, rdv}, {24'h0, exp});
  endtask

  task print_verdict();
    if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ==========================================================================
  // watchdog and output counter
  always @(posedge clk) begin
    cycles++;
    if (out_valid === 1'b1) outs++;
    if (out_valid === 1'b1 && out_masked === 1'b1) masks++;
    if (cycles == 5000) begin
      failures++;
      print_verdict();
    end
  end

  // ==========================================================================
  // main sequence
  initial begin
    failures = 0;
    checks_done = 0;
    cycles = 0;
    outs = 0;
    masks = 0;
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    fifo_pop = 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    chk(32'(path_cfg), {11'h0, 1'b1, 4'hb, 3'b111, 5'h0a, 8'hfa});
    for (int i = 0; i < 14; i++) rchk(rw_idx[i], rw_rst[i]);
    for (int i = 0; i < 14; i++) apb(1'b1, rw_idx[i], 8'h5a ^ 8'(i));
    for (int i = 0; i < 14; i++) rchk(rw_idx[i], 8'h5a ^ 8'(i));
    repeat (3) @(posedge clk);
    chk(32'(path_cfg), {11'h0, 1'b1, 4'h7, 3'b010, 5'h12, 8'h53});
    chk({18'h0, left_gain, right_gain}, {18'h0, 7'h1a, 7'h1b});
    apb(1'b1, ARLC_IDX_CURL, 8'hff);
    rchk(ARLC_IDX_CURL, 8'h1a);
    rchk(ARLC_IDX_CURR, 8'h1b);
    for (int i = 0; i < 4; i++) apb(1'b1, rsv_idx[i], 8'hff);
    for (int i = 0; i < 4; i++) rchk(rsv_idx[i], 8'h00);
    // software words are refused until the fill mode is on
    apb(1'b1, ARLC_IDX_FDAT0, 8'h11);
    apb(1'b1, ARLC_IDX_FDAT1, 8'h22);
    rchk(ARLC_IDX_CNTL, 8'h00);
    apb(1'b1, ARLC_IDX_FMODE, 8'h01);
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, ARLC_IDX_FDAT0, 8'h33);
      apb(1'b1, ARLC_IDX_FDAT1, 8'h44);
    end
    chk({16'h0, out_data}, 32'h00004433);
    rchk(ARLC_IDX_CNTL, 8'h02);
    rchk(ARLC_IDX_CNTH, 8'h00);
    rchk(ARLC_IDX_WPL, 8'h02);
    @(posedge clk);
    fifo_pop <= 1'b1;
    @(posedge clk);
    fifo_pop <= 1'b0;
    rchk(ARLC_IDX_CNTL, 8'h01);
    rchk(ARLC_IDX_RPL, 8'h01);
    apb(1'b1, ARLC_IDX_FMODE, 8'h00);
    outs = 0;
    arlc_sample_src_inst.send(4, 1);
    repeat (3) @(posedge clk);
    chk(32'(outs), 32'd4);
    apb(1'b1, ARLC_IDX_FILT, 8'hfb);
    repeat (2) @(posedge clk);
    outs = 0;
    arlc_sample_src_inst.send(4, 3);
    repeat (3) @(posedge clk);
    chk(32'(outs), 32'd2);
    // auto gain: short tick, gain pinned by the upper then the lower limit
    apb(1'b1, ARLC_IDX_TICKH, 8'h00);
    apb(1'b1, ARLC_IDX_TICKL, 8'h20);
    apb(1'b1, ARLC_IDX_MASK, 8'h02);
    apb(1'b1, ARLC_IDX_MAXG, 8'h15);
    apb(1'b1, ARLC_IDX_LEFT, 8'h90);
    repeat (40) @(posedge clk);
    chk({25'h0, left_gain}, 32'h00000015);
    apb(1'b1, ARLC_IDX_MAXG, 8'h58);
    apb(1'b1, ARLC_IDX_LEFT, 8'h98);
    repeat (40) @(posedge clk);
    chk({25'h0, left_gain}, 32'h00000018);
    // that change arms two masked samples; halving forwards only left ones
    outs = 0;
    masks = 0;
    arlc_sample_src_inst.send(8, 1);
    repeat (3) @(posedge clk);
    chk(32'(outs), 32'd4);
    chk(32'(masks), 32'd2);
    chk({16'h0, out_data}, 32'h00001206);
    // one loud sample against a low high target drops the gain one step
    repeat (40) @(posedge clk);
    apb(1'b1, ARLC_IDX_THH, 8'h02);
    apb(1'b1, ARLC_IDX_LEFT, 8'h90);
    arlc_sample_src_inst.send(1, 1);
    repeat (40) @(posedge clk);
    chk({25'h0, left_gain}, 32'h00000017);
    rchk(ARLC_IDX_CURL, 8'h17);
    print_verdict();
  end
endmodule // arlc_top_bench
